// ### rtl/hbs_pkg.sv
`default_nettype none
package hbs_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] HBS_REG_DELAY = 4'h0;
  localparam logic [3:0] HBS_REG_SPEED = 4'h1;
  localparam logic [3:0] HBS_REG_TIMEOUT = 4'h2;
  localparam logic [3:0] HBS_REG_ALLOC = 4'h3;
  localparam logic [3:0] HBS_REG_STATUS = 4'h4;
  // Reset values.
  localparam logic [15:0] HBS_DELAY_RST = 16'h0000;
  localparam logic [15:0] HBS_SPEED_RST = 16'h0064;
  localparam logic [15:0] HBS_TIMEOUT_RST = 16'h0032;
  localparam logic [15:0] HBS_ALLOC_RST = 16'h0100;
  // Setting ranges.
  localparam logic [15:0] HBS_DELAY_MAX = 16'h0032;
  localparam logic [15:0] HBS_SPEED_MAX = 16'h2710;
  localparam logic [15:0] HBS_TIMEOUT_MIN = 16'h000a;
  localparam logic [15:0] HBS_TIMEOUT_MAX = 16'h0064;
  // The brake field sits in the third nibble of the allocation word.
  localparam int HBS_ALLOC_LSB = 8;
  localparam int HBS_ALLOC_W = 4;
  localparam int HBS_TERMS = 3;
  // Timing: one tick is 10 ms of the 125 MHz control clock.
  localparam int HBS_CLK_HZ = 125000000;
  localparam int HBS_TICK_MS = 10;
  localparam int HBS_TICK_CYC = HBS_CLK_HZ / 1000 * HBS_TICK_MS;

  typedef enum logic [2:0] {
    HBS_OFF = 3'b000,
    HBS_ON = 3'b001,
    HBS_DELAY = 3'b010,
    HBS_WAIT = 3'b011,
    HBS_STOPPING = 3'b100
  } hbs_state_e;

  typedef struct packed {
    logic [15:0] delay;
    logic [15:0] speed;
    logic [15:0] timeout;
    logic [15:0] alloc;
    logic [3:0] alloc_live;
    hbs_state_e state;
    logic [31:0] div;
    logic [15:0] ticks;
    logic release_q;
    logic power;
    logic [2:0] terms;
    logic [15:0] rdata;
    logic [1:0] son_s;
    logic [1:0] alm_s;
    logic [1:0] ot_s;
    logic [1:0] zs_s;
  } hbs_state_s;
endpackage
`default_nettype wire

// ### rtl/hbs_sequencer.sv
`default_nettype none
// Function
// - Brake release drops when an alarm is present or motor power is off, except in the wait and zero-speed stopping states.
// - Overtravel alone does not apply the brake; release stays active.
// - Allocation field 0 disables, 1..3 select terminal pair; latched at reset only.
// - Each terminal is the OR of all functions routed to it.
// - Stopped servo-off drops release at once, power stays for the delay.
// - Delay register accepts 0 to 50 ticks of 10 ms, default 0, live.
// - An alarm cuts motor power at once, ignoring the delay.
// - Speed threshold accepts 0 to 10000 rpm, default 100, live.
// - Wait timeout accepts 10 to 100 ticks of 10 ms, default 50, live.
// - After power-off while rotating, brake applies when speed drops below threshold.
// - It also applies once the wait timeout expires, whichever is first.
// - The effective threshold is clamped to the motor maximum speed.
// - After an alarm zero-speed stop, power is cut at once and the brake applies when speed drops below threshold.
module hbs_sequencer
  import hbs_pkg::*;
#(
  parameter logic [15:0] MAX_SPEED = 16'h1770,
  parameter int TICK_CYC = HBS_TICK_CYC
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port.
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Drive sequence inputs.
  input wire logic servo_on_in,
  input wire logic alarm_in,
  input wire logic overtravel_in,
  input wire logic zero_speed_stop_in,
  input wire logic signed [15:0] speed_in,
  input wire logic [2:0] other_func_in,
  // Drive outputs.
  output logic motor_power_out,
  output logic brake_release_out,
  output logic [2:0] terminal_out
);
  if (TICK_CYC < 2 || MAX_SPEED == 16'h0000) begin : g_bad_params
    $error("hbs_sequencer: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  hbs_state_s q;
  hbs_state_s n;
  logic son;
  logic alm;
  logic zss;
  logic tick;
  logic [15:0] mag;
  logic [15:0] thr;
  logic slow;

  assign son = q.son_s[1];
  assign alm = q.alm_s[1];
  assign zss = q.zs_s[1];
  // Speed arrives from logic on this clock, so it is not synchronised.
  assign mag = speed_in[15] ? 16'(-speed_in) : 16'(speed_in);
  assign thr = (q.speed > MAX_SPEED) ? MAX_SPEED : q.speed;
  assign slow = mag < thr;
  assign tick = (q.div == 32'(TICK_CYC - 1));

  always_comb begin
    n = q;
    n.son_s = {q.son_s[0], servo_on_in};
    n.alm_s = {q.alm_s[0], alarm_in};
    n.ot_s = {q.ot_s[0], overtravel_in};
    n.zs_s = {q.zs_s[0], zero_speed_stop_in};
    n.div = tick ? 32'h0 : q.div + 32'h1;
    n.rdata = 16'h0000;
    if (wr_in) begin
      case (addr_in)
        HBS_REG_DELAY: begin
          if (wdata_in <= HBS_DELAY_MAX) n.delay = wdata_in;
        end
        HBS_REG_SPEED: begin
          if (wdata_in <= HBS_SPEED_MAX) n.speed = wdata_in;
        end
        HBS_REG_TIMEOUT: begin
          if (wdata_in >= HBS_TIMEOUT_MIN && wdata_in <= HBS_TIMEOUT_MAX) begin
            n.timeout = wdata_in;
          end
        end
        HBS_REG_ALLOC: n.alloc = wdata_in;
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        HBS_REG_DELAY: n.rdata = q.delay;
        HBS_REG_SPEED: n.rdata = q.speed;
        HBS_REG_TIMEOUT: n.rdata = q.timeout;
        HBS_REG_ALLOC: n.rdata = q.alloc;
        HBS_REG_STATUS: n.rdata = {10'h000, q.state, q.ot_s[1],
                                   q.power, q.release_q};
        default: n.rdata = 16'h0000;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Overtravel is deliberately absent from every exit below.
    case (q.state)
      HBS_OFF: begin
        n.power = 1'b0;
        n.release_q = 1'b0;
        if (son && !alm) begin
          n.power = 1'b1;
          n.release_q = 1'b1;
          n.state = HBS_ON;
        end
      end
      HBS_ON: begin
        n.ticks = 16'h0000;
        if (alm) begin
          n.power = 1'b0;
          if (slow) begin
            // A motor already at rest gets the brake at once.
            n.release_q = 1'b0;
            n.state = HBS_OFF;
          end else if (zss) begin
            n.state = HBS_STOPPING;
          end else begin
            n.state = HBS_WAIT;
          end
        end else if (!son) begin
          if (slow) begin
            n.release_q = 1'b0;
            n.state = HBS_DELAY;
          end else begin
            n.power = 1'b0;
            n.state = HBS_WAIT;
          end
        end
        // Restart the divider so that the first tick is a whole 10 ms and
        // the delay is never cut short by the divider phase.
        if (n.state != HBS_ON) n.div = 32'h0;
      end
      HBS_DELAY: begin
        n.release_q = 1'b0;
        if (tick) n.ticks = q.ticks + 16'h1;
        if (alm || q.ticks >= q.delay) begin
          n.power = 1'b0;
          n.state = HBS_OFF;
        end
      end
      HBS_WAIT: begin
        n.power = 1'b0;
        if (tick) n.ticks = q.ticks + 16'h1;
        if (slow || q.ticks >= q.timeout) begin
          n.release_q = 1'b0;
          n.state = HBS_OFF;
        end
      end
      HBS_STOPPING: begin
        // Power is already cut while the drive ramps to zero; the brake
        // applies once the speed drops below the threshold.
        n.power = 1'b0;
        n.ticks = 16'h0000;
        if (slow) begin
          n.release_q = 1'b0;
          n.state = HBS_OFF;
        end
      end
      default: begin
        n.state = HBS_OFF;
        n.power = 1'b0;
        n.release_q = 1'b0;
      end
    endcase
    // Rotating stops keep the brake open after power is cut until the
    // speed or time condition is met.
    if ((alm || !n.power) && n.state != HBS_WAIT &&
        n.state != HBS_STOPPING) begin
      n.release_q = 1'b0;
    end

    // Routing uses the field latched from the reset value, so a write to the allocation register never reaches it.
    for (int i = 0; i < HBS_TERMS; i++) begin
      n.terms[i] = other_func_in[i] |
        (n.release_q && q.alloc_live == 4'(i + 1));
    end
  end

  // The release follows power except in the delay state, where it is off on a powered motor, and in the wait
  // and stopping states, where the brake stays open on an unpowered motor until its stop condition is met.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.delay <= HBS_DELAY_RST;
      q.speed <= HBS_SPEED_RST;
      q.timeout <= HBS_TIMEOUT_RST;
      q.alloc <= HBS_ALLOC_RST;
      q.alloc_live <= HBS_ALLOC_RST[HBS_ALLOC_LSB +: HBS_ALLOC_W];
      q.state <= HBS_OFF;
    end else begin
      q <= n;
    end
  end

  assign rdata_out = q.rdata;
  assign motor_power_out = q.power;
  assign brake_release_out = q.release_q;
  assign terminal_out = q.terms;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_stop_cmd;
    q.state == HBS_ON && !son && !alm && slow;
  endsequence

  sequence s_rot_stop;
    q.state == HBS_ON && !son && !alm && !slow;
  endsequence

  sequence s_alarm_rest;
    q.state == HBS_ON && alm && slow;
  endsequence

  sequence s_delay_done;
    q.state == HBS_DELAY && !alm && q.ticks >= q.delay;
  endsequence

  sequence s_wait_expire;
    q.state == HBS_WAIT && q.ticks >= q.timeout;
  endsequence

  sequence s_stop_rest;
    q.state == HBS_STOPPING && slow;
  endsequence

  sequence s_start;
    q.state == HBS_OFF && son && !alm;
  endsequence

  // Helper for the wait span: counts the cycles spent in the wait state.
  logic [31:0] wait_cyc;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cyc <= 32'h0;
    end else if (q.state == HBS_WAIT) begin
      wait_cyc <= wait_cyc + 32'h1;
    end else begin
      wait_cyc <= 32'h0;
    end
  end

  AST_RELEASE_SAFE: assert property (@(posedge clk_in) disable iff (rst_in)
    (alm && slow) |=> !brake_release_out)
    else $error("release with alarm");
  AST_RELEASE_POWER: assert property (@(posedge clk_in) disable iff (rst_in)
    brake_release_out |-> motor_power_out || q.state == HBS_WAIT ||
    q.state == HBS_STOPPING) else $error("release without power");
  AST_STOP_DROP: assert property (@(posedge clk_in) disable iff (rst_in)
    s_stop_cmd |=> !brake_release_out && motor_power_out)
    else $error("stop sequence wrong");
  AST_ALARM_CUT: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state != HBS_OFF && alm) |=> !motor_power_out)
    else $error("alarm did not cut power");
  AST_DELAY_REG: assert property (@(posedge clk_in) disable iff (rst_in)
    q.delay <= HBS_DELAY_MAX) else $error("delay out of range");
  AST_TIMEOUT_REG: assert property (@(posedge clk_in) disable iff (rst_in)
    q.timeout >= HBS_TIMEOUT_MIN && q.timeout <= HBS_TIMEOUT_MAX)
    else $error("timeout out of range");
  AST_SPEED_REG: assert property (@(posedge clk_in) disable iff (rst_in)
    q.speed <= HBS_SPEED_MAX) else $error("threshold out of range");
  AST_WAIT_END: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == HBS_WAIT && slow) |=> q.state == HBS_OFF)
    else $error("slow motor did not end wait");
  AST_TICK: assert property (@(posedge clk_in) disable iff (rst_in)
    tick |=> q.div == 32'h0) else $error("tick divider wrong");
  AST_TERM_OR: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(other_func_in[0]) |=> terminal_out[0])
    else $error("terminal OR lost");

  // Sequence steps.
  AST_ROT_STOP: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rot_stop |=> !motor_power_out && brake_release_out)
    else $error("rotating stop wrong");
  AST_ALARM_REST: assert property (@(posedge clk_in) disable iff (rst_in)
    s_alarm_rest |=> !motor_power_out && !brake_release_out)
    else $error("alarm at rest wrong");
  AST_DELAY_DONE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_delay_done |=> q.state == HBS_OFF && !motor_power_out)
    else $error("delay end wrong");
  AST_WAIT_EXPIRE: assert property (@(posedge clk_in) disable iff (rst_in)
    s_wait_expire |=> q.state == HBS_OFF && !brake_release_out)
    else $error("timeout did not apply brake");
  AST_STOP_REST: assert property (@(posedge clk_in) disable iff (rst_in)
    s_stop_rest |=> !brake_release_out)
    else $error("zero-speed stop did not apply brake");
  AST_START: assert property (@(posedge clk_in) disable iff (rst_in)
    s_start |=> motor_power_out && brake_release_out)
    else $error("servo on did not start");
  AST_OT_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == HBS_ON && son && !alm) |=> brake_release_out)
    else $error("release dropped while running");
  AST_DELAY_POWER: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == HBS_DELAY && !alm && q.ticks < q.delay) |=> motor_power_out)
    else $error("power cut before delay");
  AST_WAIT_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == HBS_WAIT && !slow && q.ticks < q.timeout) |=>
    brake_release_out) else $error("brake applied early");
  AST_ALARM_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == HBS_OFF && alm) |=> !motor_power_out)
    else $error("power with alarm");
  AST_HOLD_SPAN: assert property (@(posedge clk_in) disable iff (rst_in)
    q.state == HBS_WAIT |->
    wait_cyc <= 32'(TICK_CYC) * (32'(q.timeout) + 32'h1))
    else $error("wait outlived timeout");

  // Register port and settings.
  AST_STATUS_READ: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == HBS_REG_STATUS) |=>
    rdata_out[0] == $past(brake_release_out)) else $error("status wrong");
  AST_REFUSE_DELAY: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_in && addr_in == HBS_REG_DELAY && wdata_in > HBS_DELAY_MAX) |=>
    $stable(q.delay)) else $error("bad delay taken");
  AST_REFUSE_TIMEOUT: assert property (@(posedge clk_in) disable iff (rst_in)
    (wr_in && addr_in == HBS_REG_TIMEOUT && (wdata_in < HBS_TIMEOUT_MIN ||
    wdata_in > HBS_TIMEOUT_MAX)) |=> $stable(q.timeout))
    else $error("bad timeout taken");
  AST_RDATA_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data without read");
  AST_CLAMP: assert property (@(posedge clk_in) disable iff (rst_in)
    thr <= MAX_SPEED)
    else $error("threshold not clamped");

  // Timebase and routing.
  AST_TICK_SPAN: assert property (@(posedge clk_in) disable iff (rst_in)
    q.div < 32'(TICK_CYC))
    else $error("divider overran");
  AST_TICK_STEP: assert property (@(posedge clk_in) disable iff (rst_in)
    (!tick && (q.state == HBS_DELAY || q.state == HBS_WAIT)) |=>
    q.div == $past(q.div) + 32'h1) else $error("divider skipped");
  AST_ALLOC_LIVE: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> $stable(q.alloc_live))
    else $error("allocation changed before restart");
  AST_TERM_OFF: assert property (@(posedge clk_in) disable iff (rst_in)
    q.alloc_live == 4'h0 |=> terminal_out == $past(other_func_in))
    else $error("disabled brake reached a terminal");
endmodule
`default_nettype wire

// ### sim/hbs_relay_model.sv
`default_nettype none
// Brake relay: the contact follows the coil after a pick-up lag.
module hbs_relay_model #(
  parameter int LAG = 4
) (
  // Coil side.
  input wire logic clk_in,
  input wire logic coil_in,
  // Contact side, high while the brake is powered open.
  output logic brake_free_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial brake_free_out = 1'b0;
  always @(posedge clk_in) begin
    if (coil_in !== brake_free_out) begin
      cnt <= cnt + 1;
      if (cnt == LAG) begin
        brake_free_out <= coil_in;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
`default_nettype none
module testbench
  import hbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic son = 0, alm = 0, ot = 0, zss = 0;
  logic [3:0] addr_in = '0;
  logic [15:0] wdata_in = '0;
  logic signed [15:0] spd = '0;
  logic [2:0] oth = '0;
  logic [15:0] rdata;
  logic pwr, rel, bfree;
  logic [2:0] term;
  int miscompares = 0, cmp_count = 0;
  hbs_sequencer #(.TICK_CYC(10)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata), .servo_on_in(son), .alarm_in(alm),
    .overtravel_in(ot), .zero_speed_stop_in(zss), .speed_in(spd),
    .other_func_in(oth), .motor_power_out(pwr), .brake_release_out(rel),
    .terminal_out(term));
  hbs_relay_model relay (.clk_in(clk_in), .coil_in(term[0]),
    .brake_free_out(bfree));
  initial forever #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    cyc(3);
    rst_in <= 1'b0;
    rdchk(HBS_REG_DELAY, HBS_DELAY_RST);
    rdchk(HBS_REG_SPEED, HBS_SPEED_RST);
    rdchk(HBS_REG_TIMEOUT, HBS_TIMEOUT_RST);
    rdchk(HBS_REG_ALLOC, HBS_ALLOC_RST);
    wr(HBS_REG_DELAY, 16'h0033);
    rdchk(HBS_REG_DELAY, 16'h0000);
    wr(HBS_REG_SPEED, 16'h2711);
    rdchk(HBS_REG_SPEED, 16'h0064);
    wr(HBS_REG_TIMEOUT, 16'h0009);
    wr(HBS_REG_TIMEOUT, 16'h0065);
    rdchk(HBS_REG_TIMEOUT, 16'h0032);
    wr(4'h5, 16'h1234);
    rdchk(4'h5, 16'h0000);
    wr(HBS_REG_SPEED, HBS_SPEED_MAX);
    rdchk(HBS_REG_SPEED, HBS_SPEED_MAX);
    wr(HBS_REG_TIMEOUT, HBS_TIMEOUT_MIN);
    rdchk(HBS_REG_TIMEOUT, HBS_TIMEOUT_MIN);
    wr(HBS_REG_ALLOC, 16'h0200);
    rdchk(HBS_REG_ALLOC, 16'h0200);
    $display("test registers done");
    // Other functions stay off pair 1, where the brake lives.
    oth <= 3'b100;
    son <= 1'b1;
    cyc(4);
    chk(pwr, 1'b1);
    chk(term, 3'b101);
    cyc(8);
    chk(bfree, 1'b1);
    ot <= 1'b1;
    cyc(10);
    chk(rel, 1'b1);
    rdchk(HBS_REG_STATUS, 16'h000f);
    ot <= 1'b0;
    cyc(50);
    // Delay of 3 ticks keeps torque until the brake has closed.
    wr(HBS_REG_DELAY, 16'h0003);
    son <= 1'b0;
    cyc(4);
    chk(rel, 1'b0);
    chk(term, 3'b100);
    cyc(24);
    chk(pwr, 1'b1);
    cyc(20);
    chk(pwr, 1'b0);
    $display("test stopped servo off done");
    son <= 1'b1;
    cyc(4);
    spd <= 16'sd6500;
    son <= 1'b0;
    cyc(6);
    chk(pwr, 1'b0);
    chk(rel, 1'b1);
    spd <= -16'sd5000;
    cyc(3);
    chk(rel, 1'b0);
    son <= 1'b1;
    spd <= 16'sd7000;
    cyc(4);
    son <= 1'b0;
    cyc(80);
    chk(rel, 1'b1);
    cyc(40);
    chk(rel, 1'b0);
    $display("test rotating servo off done");
    spd <= 16'sd0;
    son <= 1'b1;
    cyc(4);
    alm <= 1'b1;
    cyc(4);
    chk(pwr, 1'b0);
    chk(rel, 1'b0);
    son <= 1'b0;
    alm <= 1'b0;
    cyc(5);
    son <= 1'b1;
    cyc(4);
    spd <= 16'sd7000;
    zss <= 1'b1;
    alm <= 1'b1;
    cyc(4);
    chk(pwr, 1'b0);
    chk(rel, 1'b1);
    spd <= 16'sd0;
    cyc(3);
    chk(rel, 1'b0);
    oth <= 3'b001;
    cyc(2);
    chk(term, 3'b001);
    $display("test alarm done");
    report_and_stop();
  end
endmodule
`default_nettype wire
